// ==== cpd_pkg.sv ====
// constants, types and register map of the clock pin control block
// assumes one 50 MHz clock and an AXI4-Lite register port
package cpd_pkg;
    localparam int          CLOCK_HZ        = 50_000_000;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;

    // register byte offsets
    localparam logic [3:0]  EXT_CLK_CTL_OFS = 4'h0;
    localparam logic [3:0]  CLK_SRC_CTL_OFS = 4'h4;
    localparam logic [3:0]  PIN_MUX_OFS     = 4'h8;
    localparam logic [3:0]  STATUS_OFS      = 4'hc;

    // external_clock_ctl_reg fields
    localparam int          DIV_LSB         = 0;
    localparam int          DIV_W           = 2;
    localparam int          PIN_SEL_BIT     = 6;
    // clock_source_ctl_reg fields
    localparam int          XTAL_OFF_BIT    = 14;
    localparam int          EXTIN_OFF_BIT   = 13;
    // pin mux register field
    localparam int          MUX_CLKOUT_BIT  = 0;

    // status register fields
    localparam int          STAT_DIV_LSB    = 0;
    localparam int          STAT_CLK_BIT    = 2;
    localparam int          STAT_REF_BIT    = 3;
    localparam int          STAT_EXT_BIT    = 4;
    localparam int          STAT_XTAL_BIT   = 5;
    localparam int          STAT_PIN_BIT    = 6;

    // reset values
    localparam logic [31:0] EXT_CLK_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] CLK_SRC_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] PIN_MUX_RST     = 32'h0000_0000;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // half periods of the divided clock in clock_i cycles
    localparam int          CNT_W           = 3;
    localparam logic [2:0]  HALF_BY1        = 3'h1;
    localparam logic [2:0]  HALF_BY2        = 3'h2;
    localparam logic [2:0]  HALF_BY4        = 3'h4;

    typedef enum logic [1:0] {
        DIV_BY4 = 2'h0,
        DIV_BY2 = 2'h1,
        DIV_BY1 = 2'h2,
        DIV_OFF = 2'h3
    } cpd_div_e;

    typedef struct packed {
        cpd_div_e div_sel;
        logic     pin_sel;
        logic     xtal_off;
        logic     extin_off;
        logic     mux_clkout;
    } cpd_ctl_s;

    localparam int          SYNC_N          = 3;
endpackage

// ==== cpd_divider.sv ====
// divider that turns clock_i into the system clock reference and the pin clock
// assumes div_sel_i comes from registers on the same clock
`timescale 1ns/100ps
module cpd_divider (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire cpd_pkg::cpd_div_e div_sel_i,
    output logic                   sys_ref_o,
    output logic                   clk_out_o
);
    logic [cpd_pkg::CNT_W-1:0] cnt;
    logic [cpd_pkg::CNT_W-1:0] next_cnt;
    logic                      next_clk_out;
    logic                      next_sys_ref;
    logic [cpd_pkg::CNT_W-1:0] half;

    always_comb begin
        case (div_sel_i)
            cpd_pkg::DIV_BY1: half = cpd_pkg::HALF_BY1;
            cpd_pkg::DIV_BY2: half = cpd_pkg::HALF_BY2;
            default:          half = cpd_pkg::HALF_BY4;
        endcase
        // the reference toggles every cycle and stands for the system clock
        next_sys_ref = ~sys_ref_o;
        next_cnt     = cnt + 3'h1;
        next_clk_out = clk_out_o;
        if (div_sel_i == cpd_pkg::DIV_OFF) begin
            next_cnt     = '0;
            next_clk_out = 1'b0;
        end else if (next_cnt >= half) begin
            next_cnt     = '0;
            next_clk_out = ~clk_out_o;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cnt       <= '0;
            clk_out_o <= 1'b0;
            sys_ref_o <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            clk_out_o <= next_clk_out;
            sys_ref_o <= next_sys_ref;
        end
    end
endmodule

// ==== cpd_clock_pin_ctl.sv ====
// clock pin control: output divider, pin mux and external clock source selection
// assumes an AXI4-Lite master on clock_i; pin inputs are asynchronous
// How it works
// - pin clock runs at system clock, half or quarter, chosen by bits 1:0
// - after reset the divider field selects divide-by-four
// - divider field value 3 stops the pin clock entirely
// - pin carries the clock only while its mux selects clock output
// - select bit picks which shared pin feeds the external oscillator path
// - bit 14 of clock source control disables the crystal oscillator
// - bit 13 of clock source control disables the external clock input
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cpd_clock_pin_ctl (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [3:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // shared clock output pin and its other function
    input  wire logic        gpio_func_out_i,
    input  wire logic        gpio_func_oe_n_i,
    output logic             clkout_shared_pin_o,
    output logic             clkout_shared_pin_oe_n_o,
    // clock source pins
    input  wire logic        default_ext_clk_pin_i,
    input  wire logic        alt_ext_clk_pin_i,
    input  wire logic        crystal_input_pin_i,
    output logic             ext_osc_input_o,
    output logic             xtal_osc_en_o,
    output logic             ext_path_en_o
);
    // ---------------- registers ----------------
    logic [31:0] ext_clk_ctl;
    logic [31:0] clk_src_ctl;
    logic [31:0] pin_mux;
    logic [31:0] next_ext_clk_ctl;
    logic [31:0] next_clk_src_ctl;
    logic [31:0] next_pin_mux;

    cpd_pkg::cpd_ctl_s ctl;

    // ---------------- write channel state ----------------
    logic        aw_held;
    logic [3:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic [3:0]  next_aw_addr;
    logic        next_w_held;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    logic [1:0]  next_bresp;

    // ---------------- read channel state ----------------
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // ---------------- pin side ----------------
    logic [cpd_pkg::SYNC_N-1:0] sync_a;
    logic [cpd_pkg::SYNC_N-1:0] sync_b;
    logic                       sys_ref;
    logic                       div_clk;
    logic                       next_pin;
    logic                       next_pin_oe_n;
    logic                       next_ext_in;
    logic                       next_xtal_en;
    logic                       next_ext_en;
    logic [31:0]                status;

    logic        aw_go;
    logic        w_go;
    logic        do_write;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        ar_go;

    // merge byte lanes of a write into a register value
    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_mapped(input logic [3:0] a);
        logic ok;
        ok = 1'b0;
        if (a == cpd_pkg::EXT_CLK_CTL_OFS) begin
            ok = 1'b1;
        end else if (a == cpd_pkg::CLK_SRC_CTL_OFS) begin
            ok = 1'b1;
        end else if (a == cpd_pkg::PIN_MUX_OFS) begin
            ok = 1'b1;
        end else if (a == cpd_pkg::STATUS_OFS) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // ---------------- control fields ----------------
    always_comb begin
        ctl.div_sel    = cpd_pkg::cpd_div_e'(ext_clk_ctl[cpd_pkg::DIV_LSB +: cpd_pkg::DIV_W]);
        ctl.pin_sel    = ext_clk_ctl[cpd_pkg::PIN_SEL_BIT];
        ctl.xtal_off   = clk_src_ctl[cpd_pkg::XTAL_OFF_BIT];
        ctl.extin_off  = clk_src_ctl[cpd_pkg::EXTIN_OFF_BIT];
        ctl.mux_clkout = pin_mux[cpd_pkg::MUX_CLKOUT_BIT];
    end

    cpd_divider u_divider (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .div_sel_i (ctl.div_sel),
        .sys_ref_o (sys_ref),
        .clk_out_o (div_clk)
    );

    // ---------------- write path ----------------
    always_comb begin
        aw_go    = s_axi_awvalid_i && s_axi_awready_o;
        w_go     = s_axi_wvalid_i && s_axi_wready_o;
        wr_addr  = aw_held ? aw_addr : s_axi_awaddr_i;
        wr_data  = w_held ? w_data : s_axi_wdata_i;
        wr_strb  = w_held ? w_strb : s_axi_wstrb_i;
        do_write = (aw_held || aw_go) && (w_held || w_go);

        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid_o;
        next_bresp   = s_axi_bresp_o;
        next_ext_clk_ctl = ext_clk_ctl;
        next_clk_src_ctl = clk_src_ctl;
        next_pin_mux     = pin_mux;

        if (aw_go) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (w_go) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = cpd_pkg::RESP_OKAY;
            if (wr_addr == cpd_pkg::EXT_CLK_CTL_OFS) begin
                next_ext_clk_ctl = apply_strb(ext_clk_ctl, wr_data, wr_strb);
            end else if (wr_addr == cpd_pkg::CLK_SRC_CTL_OFS) begin
                next_clk_src_ctl = apply_strb(clk_src_ctl, wr_data, wr_strb);
            end else if (wr_addr == cpd_pkg::PIN_MUX_OFS) begin
                next_pin_mux = apply_strb(pin_mux, wr_data, wr_strb);
            end else if (wr_addr != cpd_pkg::STATUS_OFS) begin
                next_bresp = cpd_pkg::RESP_SLVERR;
            end
        end
        // a channel is open only while nothing of it is held and no response waits
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ext_clk_ctl     <= cpd_pkg::EXT_CLK_CTL_RST;
            clk_src_ctl     <= cpd_pkg::CLK_SRC_CTL_RST;
            pin_mux         <= cpd_pkg::PIN_MUX_RST;
            aw_held         <= 1'b0;
            aw_addr         <= 4'h0;
            w_held          <= 1'b0;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= cpd_pkg::RESP_OKAY;
        end else begin
            ext_clk_ctl     <= next_ext_clk_ctl;
            clk_src_ctl     <= next_clk_src_ctl;
            pin_mux         <= next_pin_mux;
            aw_held         <= next_aw_held;
            aw_addr         <= next_aw_addr;
            w_held          <= next_w_held;
            w_data          <= next_w_data;
            w_strb          <= next_w_strb;
            s_axi_awready_o <= next_awready;
            s_axi_wready_o  <= next_wready;
            s_axi_bvalid_o  <= next_bvalid;
            s_axi_bresp_o   <= next_bresp;
        end
    end

    // ---------------- read path ----------------
    always_comb begin
        status = 32'h0000_0000;
        status[cpd_pkg::STAT_DIV_LSB +: cpd_pkg::DIV_W] = ctl.div_sel;
        status[cpd_pkg::STAT_CLK_BIT]  = div_clk;
        status[cpd_pkg::STAT_REF_BIT]  = sys_ref;
        status[cpd_pkg::STAT_EXT_BIT]  = ext_osc_input_o;
        status[cpd_pkg::STAT_XTAL_BIT] = sync_b[2];
        status[cpd_pkg::STAT_PIN_BIT]  = !clkout_shared_pin_oe_n_o && ctl.mux_clkout;

        ar_go        = s_axi_arvalid_i && s_axi_arready_o;
        next_rvalid  = s_axi_rvalid_o;
        next_rdata   = s_axi_rdata_o;
        next_rresp   = s_axi_rresp_o;
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
        if (ar_go) begin
            next_rvalid = 1'b1;
            next_rresp  = cpd_pkg::RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr_i == cpd_pkg::EXT_CLK_CTL_OFS) begin
                next_rdata = ext_clk_ctl;
            end else if (s_axi_araddr_i == cpd_pkg::CLK_SRC_CTL_OFS) begin
                next_rdata = clk_src_ctl;
            end else if (s_axi_araddr_i == cpd_pkg::PIN_MUX_OFS) begin
                next_rdata = pin_mux;
            end else if (s_axi_araddr_i == cpd_pkg::STATUS_OFS) begin
                next_rdata = status;
            end
            if (!is_mapped(s_axi_araddr_i)) begin
                next_rresp = cpd_pkg::RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= cpd_pkg::RESP_OKAY;
        end else begin
            s_axi_arready_o <= next_arready;
            s_axi_rvalid_o  <= next_rvalid;
            s_axi_rdata_o   <= next_rdata;
            s_axi_rresp_o   <= next_rresp;
        end
    end

    // ---------------- pins ----------------
    always_comb begin
        if (ctl.mux_clkout) begin
            next_pin      = div_clk;
            next_pin_oe_n = 1'b0;
        end else begin
            next_pin      = gpio_func_out_i;
            next_pin_oe_n = gpio_func_oe_n_i;
        end
        // sync_b order: default pin, alternate pin, crystal pin
        next_ext_in  = (ctl.pin_sel ? sync_b[1] : sync_b[0]) && !ctl.extin_off;
        next_xtal_en = !ctl.xtal_off;
        next_ext_en  = !ctl.extin_off;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync_a                   <= '0;
            sync_b                   <= '0;
            clkout_shared_pin_o      <= 1'b0;
            clkout_shared_pin_oe_n_o <= 1'b1;
            ext_osc_input_o          <= 1'b0;
            xtal_osc_en_o            <= 1'b0;
            ext_path_en_o            <= 1'b0;
        end else begin
            sync_a                   <= {crystal_input_pin_i, alt_ext_clk_pin_i, default_ext_clk_pin_i};
            sync_b                   <= sync_a;
            clkout_shared_pin_o      <= next_pin;
            clkout_shared_pin_oe_n_o <= next_pin_oe_n;
            ext_osc_input_o          <= next_ext_in;
            xtal_osc_en_o            <= next_xtal_en;
            ext_path_en_o            <= next_ext_en;
        end
    end
endmodule

// ==== cpd_clock_pin_ctl_checker.sv ====
// assertions on the clock pin control ports, using shadow copies of the control registers
// assumes write address and data are offered together with all byte strobes set
`timescale 1ns/100ps
module cpd_clock_pin_ctl_checker (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    input  wire logic        s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic        s_axi_wvalid_i,
    input  wire logic        s_axi_wready_o,
    input  wire logic [1:0]  s_axi_bresp_o,
    input  wire logic        s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic        gpio_func_oe_n_i,
    input  wire logic        default_ext_clk_pin_i,
    input  wire logic        alt_ext_clk_pin_i,
    input  wire logic        clkout_shared_pin_o,
    input  wire logic        clkout_shared_pin_oe_n_o,
    input  wire logic        ext_osc_input_o,
    input  wire logic        xtal_osc_en_o,
    input  wire logic        ext_path_en_o
);
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [31:0] ext_ctl;
    logic [31:0] src_ctl;
    logic [31:0] mux_ctl;
    logic        bvalid_q;
    logic        pin_q;
    logic [3:0]  sel_q;
    logic [6:0]  run;
    logic [6:0]  quiet;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // shadows lag the design registers by one edge, like its registered outputs
    always_ff @(posedge clock_i) begin
        sel_q <= {sel_q[2:0], ext_ctl[6] ? alt_ext_clk_pin_i : default_ext_clk_pin_i};
        if (s_axi_awvalid_i && s_axi_awready_o) wr_addr <= s_axi_awaddr_i;
        if (s_axi_wvalid_i && s_axi_wready_o) wr_data <= s_axi_wdata_i;
        bvalid_q <= s_axi_bvalid_o;
        pin_q    <= clkout_shared_pin_o;
        run      <= (clkout_shared_pin_o != pin_q) ? 7'h1 : ((run == 7'h7f) ? run : run + 7'h1);
        quiet    <= (quiet == 7'h7f) ? quiet : quiet + 7'h1;
        if (rst_i) begin
            ext_ctl  <= 32'h0;
            src_ctl  <= 32'h0;
            mux_ctl  <= 32'h0;
            bvalid_q <= 1'b0;
            pin_q    <= 1'b0;
            run      <= 7'h0;
            quiet    <= 7'h0;
        end else if (s_axi_bvalid_o && !bvalid_q && s_axi_bresp_o == cpd_pkg::RESP_OKAY) begin
            quiet <= 7'h0;
            if (wr_addr == cpd_pkg::EXT_CLK_CTL_OFS) ext_ctl <= wr_data;
            if (wr_addr == cpd_pkg::CLK_SRC_CTL_OFS) src_ctl <= wr_data;
            if (wr_addr == cpd_pkg::PIN_MUX_OFS) mux_ctl <= wr_data;
        end
    end

    xtal_en_a: assert property (!$past(rst_i) |-> xtal_osc_en_o == !src_ctl[14])
        else $error("crystal enable does not follow its disable bit");
    ext_en_a: assert property (!$past(rst_i) |-> ext_path_en_o == !src_ctl[13])
        else $error("external path enable does not follow its disable bit");
    pin_oe_a: assert property (!$past(rst_i) |->
        clkout_shared_pin_oe_n_o == (mux_ctl[0] ? 1'b0 : $past(gpio_func_oe_n_i)))
        else $error("pin enable does not follow the mux selection");
    pin_off_a: assert property (quiet > 7'h4 && mux_ctl[0] && ext_ctl[1:0] == 2'h3 |-> !clkout_shared_pin_o)
        else $error("pin clock runs while switched off");
    half_period_a: assert property (quiet > 7'h14 && mux_ctl[0] && ext_ctl[1:0] != 2'h3 && clkout_shared_pin_o != pin_q
        |-> run == ((ext_ctl[1:0] == 2'h0) ? 7'h4 : ((ext_ctl[1:0] == 2'h1) ? 7'h2 : 7'h1)))
        else $error("pin clock half period wrong for divider code");
    ext_osc_a: assert property (quiet > 7'h8 && sel_q[1] == sel_q[2] && sel_q[2] == sel_q[3]
        |-> ext_osc_input_o == (sel_q[2] && !src_ctl[13]))
        else $error("external oscillator input follows the wrong pin");
    bus_resp_a: assert property ($rose(s_axi_bvalid_o) |->
        s_axi_bresp_o == ((wr_addr[1:0] == 2'h0) ? cpd_pkg::RESP_OKAY : cpd_pkg::RESP_SLVERR))
        else $error("write response code wrong for address");
    resp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before taken");

    cover property (mux_ctl[0] && ext_ctl[1:0] == 2'h2 && clkout_shared_pin_o != pin_q);
    cover property (ext_ctl[6] && ext_osc_input_o);
    cover property ($rose(s_axi_bvalid_o) && s_axi_bresp_o == cpd_pkg::RESP_SLVERR);
endmodule

// ==== cpd_pin_partner.sv ====
// model of the pins around the block: two oscillator sources, a crystal and the other pin function
// assumes the bench clock; every level changes just after a rising edge, at rates taken from the bits of one counter
`timescale 1ns/100ps
module cpd_pin_partner (
    input  wire logic clock_i,
    output logic      default_ext_clk_pin_o,
    output logic      alt_ext_clk_pin_o,
    output logic      crystal_input_pin_o,
    output logic      gpio_func_out_o,
    output logic      gpio_func_oe_n_o
);
    logic [7:0] tick = 8'h0;

    always @(posedge clock_i) tick <= tick + 8'h1;

    assign default_ext_clk_pin_o = tick[3];
    assign alt_ext_clk_pin_o     = tick[4] ^ tick[2];
    assign crystal_input_pin_o   = tick[1];
    assign gpio_func_out_o       = tick[0] ^ tick[2];
    assign gpio_func_oe_n_o      = tick[1] ^ tick[3];
endmodule

// ==== cpd_clock_pin_ctl_tb.sv ====
// self-checking bench for the clock pin control block, as a bus master
// assumes the pin partner model and the port checker bound below
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module cpd_clock_pin_ctl_tb;
    logic        clock_i = 1'b0;
    logic        rst_i   = 1'b1;
    logic [3:0]  awaddr  = 4'h0;
    logic [3:0]  araddr  = 4'h0;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        fn_out, fn_oe_n, dflt_pin, alt_pin, xtal_pin, pin, pin_oe_n, ext_osc, xtal_en, ext_en;
    int          errors    = 0;
    int          cmp_count = 0;

    always #10 clock_i = ~clock_i;

    cpd_pin_partner i_partner (.clock_i(clock_i), .default_ext_clk_pin_o(dflt_pin), .alt_ext_clk_pin_o(alt_pin),
        .crystal_input_pin_o(xtal_pin), .gpio_func_out_o(fn_out), .gpio_func_oe_n_o(fn_oe_n));

    cpd_clock_pin_ctl i_dut (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .gpio_func_out_i(fn_out),
        .gpio_func_oe_n_i(fn_oe_n), .clkout_shared_pin_o(pin), .clkout_shared_pin_oe_n_o(pin_oe_n),
        .default_ext_clk_pin_i(dflt_pin), .alt_ext_clk_pin_i(alt_pin), .crystal_input_pin_i(xtal_pin),
        .ext_osc_input_o(ext_osc), .xtal_osc_en_o(xtal_en), .ext_path_en_o(ext_en));

    task automatic stop_test();
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
        bit aw_done, w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock_i);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        @(posedge clock_i);
        bready <= 1'b1;
        do @(posedge clock_i); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHECK("bresp", exp, bresp)
    endtask

    task automatic read_check(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clock_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge clock_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHECK("rdata", exp, rdata)
        `CHECK("rresp", exp_resp, rresp)
    endtask

    // edges until the pin clock is seen to rise
    task automatic wait_rise(output int n);
        logic prev;
        n = 0;
        do begin
            prev = pin;
            @(posedge clock_i);
            n++;
        end while (!(pin === 1'b1 && prev === 1'b0) && n < 40);
    endtask

    task automatic ext_check(input logic sel, input logic en);
        logic [4:0] h;
        h = 5'h0;
        for (int i = 0; i < 60; i++) begin
            @(posedge clock_i);
            h = {h[3:0], sel ? alt_pin : dflt_pin};
            if (i > 8 && (h[4:2] == 3'h0 || h[4:2] == 3'h7))
                `CHECK("ext_osc", h[3] & en, ext_osc)
        end
    endtask

    task automatic test_reset();
        read_check(cpd_pkg::EXT_CLK_CTL_OFS, cpd_pkg::EXT_CLK_CTL_RST, cpd_pkg::RESP_OKAY);
        read_check(cpd_pkg::CLK_SRC_CTL_OFS, cpd_pkg::CLK_SRC_CTL_RST, cpd_pkg::RESP_OKAY);
        read_check(cpd_pkg::PIN_MUX_OFS, cpd_pkg::PIN_MUX_RST, cpd_pkg::RESP_OKAY);
        `CHECK("xtal_en", 1'b1, xtal_en)
        `CHECK("ext_en", 1'b1, ext_en)
    endtask

    task automatic test_divide();
        int n;
        bus_write(cpd_pkg::PIN_MUX_OFS, 32'h1, cpd_pkg::RESP_OKAY);
        repeat (3) @(posedge clock_i);
        `CHECK("pin_oe_n", 1'b0, pin_oe_n)
        wait_rise(n);
        wait_rise(n);
        `CHECK("reset period", 8, n)
        for (int c = 2; c >= 0; c--) begin
            bus_write(cpd_pkg::EXT_CLK_CTL_OFS, 32'(c), cpd_pkg::RESP_OKAY);
            wait_rise(n);
            wait_rise(n);
            `CHECK("period", 8 >> c, n)
        end
        bus_write(cpd_pkg::EXT_CLK_CTL_OFS, 32'h3, cpd_pkg::RESP_OKAY);
        repeat (4) @(posedge clock_i);
        repeat (20) begin
            @(posedge clock_i);
            `CHECK("pin off", 1'b0, pin)
        end
    endtask

    task automatic test_mux();
        logic fo;
        logic fe;
        bus_write(cpd_pkg::PIN_MUX_OFS, 32'ha5a5_a5a4, cpd_pkg::RESP_OKAY);
        read_check(cpd_pkg::PIN_MUX_OFS, 32'ha5a5_a5a4, cpd_pkg::RESP_OKAY);
        fo = fn_out;
        fe = fn_oe_n;
        repeat (16) begin
            @(posedge clock_i);
            `CHECK("pin", fo, pin)
            `CHECK("pin_oe_n", fe, pin_oe_n)
            fo = fn_out;
            fe = fn_oe_n;
        end
    endtask

    task automatic test_source();
        bus_write(cpd_pkg::CLK_SRC_CTL_OFS, 32'h4000, cpd_pkg::RESP_OKAY);
        repeat (3) @(posedge clock_i);
        `CHECK("xtal_en", 1'b0, xtal_en)
        `CHECK("ext_en", 1'b1, ext_en)
        ext_check(1'b0, 1'b1);
        bus_write(cpd_pkg::EXT_CLK_CTL_OFS, 32'h40, cpd_pkg::RESP_OKAY);
        ext_check(1'b1, 1'b1);
        bus_write(cpd_pkg::CLK_SRC_CTL_OFS, 32'h2000, cpd_pkg::RESP_OKAY);
        repeat (3) @(posedge clock_i);
        `CHECK("xtal_en", 1'b1, xtal_en)
        `CHECK("ext_en", 1'b0, ext_en)
        ext_check(1'b1, 1'b0);
    endtask

    task automatic test_bus();
        bus_write(4'h1, 32'hffff_ffff, cpd_pkg::RESP_SLVERR);
        read_check(4'h1, 32'h0, cpd_pkg::RESP_SLVERR);
        bus_write(cpd_pkg::STATUS_OFS, 32'hffff_ffff, cpd_pkg::RESP_OKAY);
        read_check(cpd_pkg::EXT_CLK_CTL_OFS, 32'h40, cpd_pkg::RESP_OKAY);
        read_check(cpd_pkg::CLK_SRC_CTL_OFS, 32'h2000, cpd_pkg::RESP_OKAY);
    endtask

    initial begin
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        test_reset();
        test_divide();
        test_mux();
        test_source();
        test_bus();
        stop_test();
    end

    initial begin
        #400_000;
        errors++;
        stop_test();
    end
endmodule

bind cpd_clock_pin_ctl cpd_clock_pin_ctl_checker i_chk (.clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .gpio_func_oe_n_i(gpio_func_oe_n_i), .default_ext_clk_pin_i(default_ext_clk_pin_i),
    .alt_ext_clk_pin_i(alt_ext_clk_pin_i), .clkout_shared_pin_o(clkout_shared_pin_o),
    .clkout_shared_pin_oe_n_o(clkout_shared_pin_oe_n_o), .ext_osc_input_o(ext_osc_input_o),
    .xtal_osc_en_o(xtal_osc_en_o), .ext_path_en_o(ext_path_en_o));
